// File: trv_table_read.sv
`timescale 1ns/10ps
`include "trv_regs.svh"
// Notes on behaviour
// - reset loads the program counter with vector zero
// - timer overflow branches to 008h only if interrupt enabled and stack not full
// - table read sends low byte to operand, upper part to table high register
// - current-page read, option off: pc bits 10..8 then table pointer
// - current-page read, option on: page select bits 2..0 then table pointer
// - last-page read forces upper bits to ones
// - extended page option off by default; page select then has no effect
// - table pointer and page select are readable and writable
// - table high register is read only, updated only by table reads
// - table high bits above the word's upper part read zero
// - program words are 14 bits over 2048 locations
// - every table read takes exactly two instruction cycles
// - data memory is 8 bits wide, registers then general ram from 20h
// - single bits settable and clearable except protected bits
// - data memory reachable indirectly via the memory pointer
// - accesses to address zero are redirected to the pointer's location
module trv_table_read #(
   parameter int DATA_DEPTH = 128,
   parameter int PROG_W = 14,
   parameter bit EXT_PAGE_OPTION = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   // core side
   input wire logic [1:0] table_op,
   input wire logic [6:0] table_dest,
   input wire logic timer_overflow,
   input wire logic timer_int_en,
   input wire logic stack_full,
   input wire logic [10:0] pc_in,
   output logic pc_load,
   output logic [10:0] pc_load_value,
   output logic table_busy,
   output logic table_done,
   // program memory side
   output logic prog_rd,
   output logic [10:0] prog_addr,
   input wire logic [PROG_W-1:0] prog_data,
   // data memory access from core
   input wire logic dm_wr,
   input wire logic dm_rd,
   input wire logic [6:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   input wire logic dm_bit_set,
   input wire logic dm_bit_clr,
   input wire logic [2:0] dm_bit_sel,
   output logic [7:0] dm_rdata
);
   trv_pkg::trv_state_e state_reg, state_next;
   logic [1:0] op_reg;
   logic [6:0] dest_reg;
   logic [10:0] table_addr;
   logic [7:0] table_pointer_low_reg;
   logic [7:0] table_high_byte_reg;
   logic [7:0] table_page_select_reg;
   logic [6:0] indirect_address_pointer_reg;
   logic [7:0] ram_reg [DATA_DEPTH];
   logic [6:0] eff_addr;
   logic is_indirect;
   logic [7:0] cur_val;
   logic [7:0] bit_val;
   logic [7:0] wr_val;
   logic wr_en;
   logic [7:0] protect_mask;
   logic ext_page_en;
   logic [6:0] dest_addr;
   logic [7:0] ptr_target;
   logic [7:0] dest_target;
   logic [1:0] busy_cnt_reg;

   function automatic logic [6:0] resolve_addr(input logic [6:0] a, input logic [6:0] ptr);
      resolve_addr = (a == `TRV_ADDR_INDIRECT) ? ptr : a;
   endfunction

   function automatic logic is_table_op(input logic [1:0] op);
      is_table_op = (op == trv_pkg::TRV_OP_RDC) || (op == trv_pkg::TRV_OP_RDL);
   endfunction

   assign ext_page_en = EXT_PAGE_OPTION;

   trv_addr_gen u_addr_gen (
      .op(op_reg),
      .ext_page_en(ext_page_en),
      .pc(pc_in),
      .table_pointer_low(table_pointer_low_reg),
      .table_page_select(table_page_select_reg),
      .table_addr(table_addr)
   );

   // two-cycle sequence: fetch then write back
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         trv_pkg::TRV_ST_IDLE: begin
            if (is_table_op(table_op)) begin
               state_next = trv_pkg::TRV_ST_FETCH;
            end
         end
         trv_pkg::TRV_ST_FETCH: state_next = trv_pkg::TRV_ST_DONE;
         trv_pkg::TRV_ST_DONE: state_next = trv_pkg::TRV_ST_IDLE;
         default: state_next = trv_pkg::TRV_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= trv_pkg::TRV_ST_IDLE;
         op_reg <= trv_pkg::TRV_OP_NONE;
         dest_reg <= 7'h00;
      end else begin
         state_reg <= state_next;
         if (state_reg == trv_pkg::TRV_ST_IDLE && state_next == trv_pkg::TRV_ST_FETCH) begin
            op_reg <= table_op;
            dest_reg <= table_dest;
         end
      end
   end

   assign table_busy = (state_reg != trv_pkg::TRV_ST_IDLE);
   assign table_done = (state_reg == trv_pkg::TRV_ST_DONE);
   assign prog_rd = (state_reg == trv_pkg::TRV_ST_FETCH);
   assign prog_addr = table_addr;

   // vector selection; reset wins over the timer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_load <= 1'b1;
         pc_load_value <= `TRV_VEC_RESET;
      end else if (timer_overflow && timer_int_en && !stack_full) begin
         pc_load <= 1'b1;
         pc_load_value <= `TRV_VEC_TIMER;
      end else begin
         pc_load <= 1'b0;
         pc_load_value <= `TRV_VEC_RESET;
      end
   end

   // table high: only the table read writes it, software writes are dropped
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         table_high_byte_reg <= `TRV_RST_THIGH;
      end else if (prog_rd) begin
         table_high_byte_reg <= {{(8-`TRV_THIGH_W){1'b0}}, prog_data[PROG_W-1:8]};
      end
   end

   assign is_indirect = (dm_addr == `TRV_ADDR_INDIRECT);
   assign eff_addr = resolve_addr(dm_addr, indirect_address_pointer_reg);
   assign dest_addr = resolve_addr(dest_reg, indirect_address_pointer_reg);
   // these two look-ups exist only for the assertions at the end
   assign ptr_target = ram_reg[indirect_address_pointer_reg];
   assign dest_target = ram_reg[dest_addr];

   always_comb begin
      case (eff_addr)
         `TRV_ADDR_INDIRECT: cur_val = 8'h00;
         `TRV_ADDR_POINTER: cur_val = `TRV_POINTER_BIT7 | {1'b0, indirect_address_pointer_reg};
         `TRV_ADDR_TPTR: cur_val = table_pointer_low_reg;
         `TRV_ADDR_THIGH: cur_val = table_high_byte_reg;
         `TRV_ADDR_TPAGE: cur_val = table_page_select_reg;
         default: cur_val = (eff_addr >= `TRV_GP_BASE) ? ram_reg[eff_addr] : 8'h00;
      endcase
   end

   assign protect_mask = (eff_addr == `TRV_ADDR_THIGH) ? `TRV_PROT_MASK_THIGH : 8'h00;

   trv_bit_op u_bit_op (
      .data_in(cur_val),
      .bit_sel(dm_bit_sel),
      .bit_set(dm_bit_set),
      .bit_clr(dm_bit_clr),
      .protect_mask(protect_mask),
      .data_out(bit_val)
   );

   // table write-back of the low byte takes the data port in the second cycle
   always_comb begin
      wr_en = 1'b0;
      wr_val = dm_wdata;
      if (table_done) begin
         wr_en = 1'b1;
         wr_val = prog_data[7:0];
      end else if (dm_bit_set || dm_bit_clr) begin
         wr_en = 1'b1;
         wr_val = bit_val;
      end else if (dm_wr) begin
         wr_en = 1'b1;
      end
   end

   logic [6:0] wr_addr;
   logic [7:0] prog_lo_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prog_lo_reg <= 8'h00;
      end else if (prog_rd) begin
         prog_lo_reg <= prog_data[7:0];
      end
   end
   assign wr_addr = table_done ? dest_addr : eff_addr;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         table_pointer_low_reg <= `TRV_RST_TPTR;
         table_page_select_reg <= `TRV_RST_TPAGE;
         indirect_address_pointer_reg <= `TRV_RST_POINTER;
      end else if (wr_en) begin
         case (wr_addr)
            `TRV_ADDR_TPTR: table_pointer_low_reg <= table_done ? prog_lo_reg : wr_val;
            `TRV_ADDR_TPAGE: table_page_select_reg <= table_done ? prog_lo_reg : wr_val;
            `TRV_ADDR_POINTER: indirect_address_pointer_reg <= table_done ? prog_lo_reg[6:0] : wr_val[6:0];
            default: ;
         endcase
      end
   end

   // general ram from the base upward; indirect access through address zero
   always_ff @(posedge clk_sys) begin
      if (wr_en && wr_addr >= `TRV_GP_BASE) begin
         ram_reg[wr_addr] <= table_done ? prog_lo_reg : wr_val;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dm_rdata <= 8'h00;
      end else if (dm_rd) begin
         dm_rdata <= cur_val;
      end
   end

   // busy cycles are counted so that the two-cycle limit is checked as a number
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_cnt_reg <= 2'h0;
      end else if (table_busy) begin
         busy_cnt_reg <= busy_cnt_reg + 2'h1;
      end else begin
         busy_cnt_reg <= 2'h0;
      end
   end

   sequence s_start;
      state_reg == trv_pkg::TRV_ST_IDLE && is_table_op(table_op);
   endsequence
   sequence s_two;
      prog_rd ##1 table_done ##1 !table_busy;
   endsequence
   sequence s_fetch_wb;
      prog_rd ##1 (table_done && dest_addr >= `TRV_GP_BASE);
   endsequence

   two_cycle_a: assert property (@(posedge clk_sys) disable iff (rst) s_start |=> s_two)
      else $error("table read not two cycles");
   reset_vec_a: assert property (@(posedge clk_sys) rst |=> pc_load && pc_load_value == 11'h000)
      else $error("reset vector wrong");
   timer_vec_a: assert property (@(posedge clk_sys) disable iff (rst)
      timer_overflow && timer_int_en && !stack_full |=> pc_load && pc_load_value == 11'h008)
      else $error("timer vector wrong");
   timer_block_a: assert property (@(posedge clk_sys) disable iff (rst)
      timer_overflow && (!timer_int_en || stack_full) |=> !pc_load)
      else $error("timer vector taken while blocked");
   last_page_a: assert property (@(posedge clk_sys) disable iff (rst)
      prog_rd && op_reg == trv_pkg::TRV_OP_RDL |-> prog_addr == {3'h7, table_pointer_low_reg})
      else $error("last page address wrong");
   cur_page_a: assert property (@(posedge clk_sys) disable iff (rst)
      prog_rd && op_reg == trv_pkg::TRV_OP_RDC && !ext_page_en |-> prog_addr == {pc_in[10:8], table_pointer_low_reg})
      else $error("current page address wrong");
   high_load_a: assert property (@(posedge clk_sys) disable iff (rst)
      prog_rd |=> table_high_byte_reg == {2'b00, $past(prog_data[13:8])})
      else $error("table high not loaded");
   high_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !prog_rd |=> $stable(table_high_byte_reg))
      else $error("table high changed without table read");
   high_zero_a: assert property (@(posedge clk_sys) disable iff (rst) table_high_byte_reg[7:6] == 2'b00)
      else $error("table high top bits not zero");
   ext_page_a: assert property (@(posedge clk_sys) disable iff (rst)
      prog_rd && op_reg == trv_pkg::TRV_OP_RDC && ext_page_en
      |-> prog_addr == {table_page_select_reg[2:0], table_pointer_low_reg})
      else $error("extended page address wrong");
   low_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      s_fetch_wb |=> dest_target == 8'($past(prog_data, 2)))
      else $error("table low byte not written");
   ptr_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      dm_rd && dm_addr == `TRV_ADDR_POINTER |=> dm_rdata == {1'b1, $past(indirect_address_pointer_reg)})
      else $error("pointer read wrong");
   op_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      table_busy |=> $stable(op_reg) && $stable(dest_reg))
      else $error("table request taken while busy");
   busy_count_a: assert property (@(posedge clk_sys) disable iff (rst) table_busy |-> busy_cnt_reg < 2'h2)
      else $error("table read longer than two cycles");
   unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      dm_rd && eff_addr > `TRV_ADDR_POINTER && eff_addr < `TRV_GP_BASE && eff_addr != `TRV_ADDR_TPTR
      && eff_addr != `TRV_ADDR_THIGH && eff_addr != `TRV_ADDR_TPAGE |=> dm_rdata == 8'h00)
      else $error("unmapped location not zero");
   indirect_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      dm_rd && is_indirect && indirect_address_pointer_reg >= `TRV_GP_BASE |=> dm_rdata == $past(ptr_target))
      else $error("indirect read wrong");
   indirect_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      dm_rd && is_indirect && indirect_address_pointer_reg == `TRV_ADDR_INDIRECT |=> dm_rdata == 8'h00)
      else $error("indirect read of zero not zero");
endmodule // trv_table_read

// File: trv_regs.svh
`ifndef TRV_REGS_SVH
`define TRV_REGS_SVH
`define TRV_VEC_RESET 11'h000
`define TRV_VEC_TIMER 11'h008
`define TRV_ADDR_INDIRECT 7'h00
`define TRV_ADDR_POINTER 7'h01
`define TRV_ADDR_TPTR 7'h07
`define TRV_ADDR_THIGH 7'h08
`define TRV_ADDR_TPAGE 7'h1f
`define TRV_GP_BASE 7'h20
`define TRV_LAST_PAGE 3'h7
`define TRV_PAGE_LSB 8
`define TRV_THIGH_W 6
`define TRV_POINTER_BIT7 8'h80
`define TRV_RST_TPTR 8'h00
`define TRV_RST_THIGH 8'h00
`define TRV_RST_TPAGE 8'h00
`define TRV_RST_POINTER 7'h00
`define TRV_PROT_MASK_THIGH 8'hff
`endif

// File: trv_pkg.sv
package trv_pkg;
   typedef enum logic [1:0] {
      TRV_OP_NONE = 2'b00,
      TRV_OP_RDC = 2'b01,
      TRV_OP_RDL = 2'b10
   } trv_op_e;
   typedef enum logic [1:0] {
      TRV_ST_IDLE = 2'b00,
      TRV_ST_FETCH = 2'b01,
      TRV_ST_DONE = 2'b10
   } trv_state_e;
   typedef logic [10:0] trv_addr_t;
endpackage

// File: trv_addr_gen.sv
`timescale 1ns/10ps
`include "trv_regs.svh"
module trv_addr_gen (
   input wire logic [1:0] op,
   input wire logic ext_page_en,
   input wire logic [10:0] pc,
   input wire logic [7:0] table_pointer_low,
   input wire logic [7:0] table_page_select,
   output logic [10:0] table_addr
);
   always_comb begin
      case (op)
         trv_pkg::TRV_OP_RDL: table_addr = {`TRV_LAST_PAGE, table_pointer_low};
         default: begin
            if (ext_page_en) begin
               table_addr = {table_page_select[2:0], table_pointer_low};
            end else begin
               table_addr = {pc[10:`TRV_PAGE_LSB], table_pointer_low};
            end
         end
      endcase
   end
endmodule // trv_addr_gen

// File: trv_bit_op.sv
`timescale 1ns/10ps
`include "trv_regs.svh"
module trv_bit_op (
   input wire logic [7:0] data_in,
   input wire logic [2:0] bit_sel,
   input wire logic bit_set,
   input wire logic bit_clr,
   input wire logic [7:0] protect_mask,
   output logic [7:0] data_out
);
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         always_comb begin
            data_out[i] = data_in[i];
            if (!protect_mask[i] && bit_sel == 3'(i)) begin
               if (bit_set) begin
                  data_out[i] = 1'b1;
               end else if (bit_clr) begin
                  data_out[i] = 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule // trv_bit_op

// File: trv_prog_model.sv
`timescale 1ns/10ps
module trv_prog_model (
   input wire logic clk_sys,
   input wire logic prog_rd,
   input wire logic [10:0] prog_addr,
   output logic [13:0] prog_data
);
   logic [13:0] last_reg = 14'h0000;
   // 14-bit words; the pattern ties each word to its address
   function automatic logic [13:0] word_at(input logic [10:0] a);
      return {a[10:5], a[7:0] ^ 8'h5a};
   endfunction
   // a released bus shows the inverse of the last word, so a late sample cannot pass by luck
   always_comb prog_data = prog_rd ? word_at(prog_addr) : ~last_reg;
   always_ff @(posedge clk_sys) begin
      if (prog_rd) last_reg <= word_at(prog_addr);
   end
endmodule // trv_prog_model

// File: table_read_and_vector_unit_bench.sv
`timescale 1ns/10ps
`include "trv_regs.svh"
module table_read_and_vector_unit_bench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] table_op = 2'h0;
   logic [6:0] table_dest = 7'h00;
   logic [6:0] dm_addr = 7'h00;
   logic timer_overflow = 1'b0, timer_int_en = 1'b0, stack_full = 1'b0;
   logic dm_wr = 1'b0, dm_rd = 1'b0, dm_bit_set = 1'b0, dm_bit_clr = 1'b0;
   logic [10:0] pc_in = 11'h000;
   logic [7:0] dm_wdata = 8'h00;
   logic [2:0] dm_bit_sel = 3'h0;
   logic pc_load, table_busy, table_done, prog_rd;
   logic [10:0] pc_load_value, prog_addr, prog_addr_ext;
   logic [13:0] prog_data;
   logic [7:0] dm_rdata;
   logic [13:0] w;
   int num_errors = 0;
   int n_checks = 0;

   trv_table_read DUT (.clk_sys(clk_sys), .rst(rst), .table_op(table_op), .table_dest(table_dest),
      .timer_overflow(timer_overflow), .timer_int_en(timer_int_en), .stack_full(stack_full), .pc_in(pc_in),
      .pc_load(pc_load), .pc_load_value(pc_load_value), .table_busy(table_busy), .table_done(table_done),
      .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data), .dm_wr(dm_wr), .dm_rd(dm_rd),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_bit_set(dm_bit_set), .dm_bit_clr(dm_bit_clr),
      .dm_bit_sel(dm_bit_sel), .dm_rdata(dm_rdata));
   // twin with the extended page option on, fed the same traffic; only its address is watched
   trv_table_read #(.EXT_PAGE_OPTION(1'b1)) DUT_EXT (.clk_sys(clk_sys), .rst(rst), .table_op(table_op),
      .table_dest(table_dest), .timer_overflow(timer_overflow), .timer_int_en(timer_int_en),
      .stack_full(stack_full), .pc_in(pc_in), .pc_load(), .pc_load_value(), .table_busy(), .table_done(),
      .prog_rd(), .prog_addr(prog_addr_ext), .prog_data(prog_data), .dm_wr(dm_wr), .dm_rd(dm_rd),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_bit_set(dm_bit_set), .dm_bit_clr(dm_bit_clr),
      .dm_bit_sel(dm_bit_sel), .dm_rdata());
   trv_prog_model PROG (.clk_sys(clk_sys), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data));

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   function automatic logic [13:0] word_at(input logic [10:0] a);
      return {a[10:5], a[7:0] ^ 8'h5a};
   endfunction

   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task finish_test;
      if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task tick;
      @(posedge clk_sys);
      #1;
   endtask

   task wr(input logic [6:0] a, input logic [7:0] d);
      dm_addr = a;
      dm_wdata = d;
      dm_wr = 1'b1;
      tick;
      dm_wr = 1'b0;
      tick;
   endtask

   // read data is registered, so it is looked at one edge after the request
   task rd(input logic [6:0] a, input logic [7:0] exp);
      dm_addr = a;
      dm_rd = 1'b1;
      tick;
      dm_rd = 1'b0;
      check(dm_rdata, exp);
      tick;
   endtask

   task bitop(input logic [6:0] a, input logic [2:0] sel, input logic set);
      dm_addr = a;
      dm_bit_sel = sel;
      dm_bit_set = set;
      dm_bit_clr = !set;
      tick;
      dm_bit_set = 1'b0;
      dm_bit_clr = 1'b0;
      tick;
   endtask

   task tbl(input logic [1:0] op, input logic [6:0] dest, input logic [10:0] pc, input logic [10:0] ea,
            input logic [10:0] ee);
      table_op = op;
      table_dest = dest;
      pc_in = pc;
      tick;
      table_op = 2'h0;
      check({prog_rd, table_busy, table_done}, 3'b110);
      check(prog_addr, ea);
      check(prog_addr_ext, ee);
      tick;
      check(table_done, 1'b1);
      tick;
      check(table_busy, 1'b0);
   endtask

   initial begin
      tick;
      tick;
      check({pc_load, pc_load_value}, 12'h800);
      repeat (3) tick;
      rst = 1'b0;
      tick;
      rd(`TRV_ADDR_TPTR, 8'h00);
      rd(`TRV_ADDR_THIGH, 8'h00);
      rd(`TRV_ADDR_TPAGE, 8'h00);
      // timer events are kept apart from table reads, as software must arrange
      for (int i = 0; i < 8; i++) begin
         {timer_overflow, timer_int_en, stack_full} = i[2:0];
         tick;
         {timer_overflow, timer_int_en, stack_full} = 3'b000;
         check(pc_load, i == 6);
         if (i == 6) check(pc_load_value, `TRV_VEC_TIMER);
         tick;
      end
      wr(`TRV_ADDR_TPTR, 8'h34);
      rd(`TRV_ADDR_TPTR, 8'h34);
      wr(`TRV_ADDR_TPAGE, 8'h05);
      rd(`TRV_ADDR_TPAGE, 8'h05);
      wr(`TRV_ADDR_THIGH, 8'hff);
      rd(`TRV_ADDR_THIGH, 8'h00);
      bitop(`TRV_ADDR_THIGH, 3'h3, 1'b1);
      rd(`TRV_ADDR_THIGH, 8'h00);
      rd(7'h02, 8'h00);
      wr(7'h20, 8'h81);
      bitop(7'h20, 3'h2, 1'b1);
      bitop(7'h20, 3'h7, 1'b0);
      rd(7'h20, 8'h05);
      wr(`TRV_ADDR_POINTER, 8'h21);
      rd(`TRV_ADDR_POINTER, 8'ha1);
      wr(`TRV_ADDR_INDIRECT, 8'h3c);
      rd(7'h21, 8'h3c);
      rd(`TRV_ADDR_INDIRECT, 8'h3c);
      tbl(2'h1, 7'h22, 11'h3ab, 11'h334, 11'h534);
      w = word_at(11'h334);
      rd(7'h22, w[7:0]);
      rd(`TRV_ADDR_THIGH, {2'b00, w[13:8]});
      tbl(2'h2, `TRV_ADDR_INDIRECT, 11'h0ab, 11'h734, 11'h734);
      w = word_at(11'h734);
      rd(7'h21, w[7:0]);
      rd(`TRV_ADDR_THIGH, {2'b00, w[13:8]});
      // a second reset in mid-run must bring back the vector and the register defaults
      rst = 1'b1;
      tick;
      check({pc_load, pc_load_value}, {1'b1, `TRV_VEC_RESET});
      rst = 1'b0;
      tick;
      check(pc_load, 1'b0);
      rd(`TRV_ADDR_THIGH, `TRV_RST_THIGH);
      rd(`TRV_ADDR_INDIRECT, 8'h00);
      rd(`TRV_ADDR_TPTR, `TRV_RST_TPTR);
      finish_test;
   end

   initial begin
      #20000;
      num_errors++;
      finish_test;
   end
endmodule // table_read_and_vector_unit_bench
